// [rtl/stee_params.svh]
// constants of the system-management / thermal exception entry unit
// assumes a 32-bit machine state word, bit 0 the least significant
`ifndef STEE_PARAMS_SVH
`define STEE_PARAMS_SVH

// machine_state field positions
`define STEE_POW_BIT 18
`define STEE_ILE_BIT 16
`define STEE_EE_BIT 15
`define STEE_PR_BIT 14
`define STEE_FP_BIT 13
`define STEE_ME_BIT 12
`define STEE_FE0_BIT 11
`define STEE_SE_BIT 10
`define STEE_BE_BIT 9
`define STEE_FE1_BIT 8
`define STEE_IP_BIT 6
`define STEE_IR_BIT 5
`define STEE_DR_BIT 4
`define STEE_PM_BIT 2
`define STEE_RI_BIT 1
`define STEE_LE_BIT 0

// bits cleared in machine_state on entry, data_endian included (it is refilled)
`define STEE_MSR_CLR_MASK 32'h0004EF37
// bits of machine_state kept in saved_status, the others read as zero
`define STEE_SAVE_KEEP_MASK 32'h87C0FFFF

// vector bases selected by vector_upper, and the vector offsets
`define STEE_VEC_BASE_LO 32'h00000000
`define STEE_VEC_BASE_HI 32'hFFF00000
`define STEE_SMI_VEC_OFS 32'h00001400
`define STEE_THM_VEC_OFS 32'h00001700

// reset values
`define STEE_WORD_RST 32'h00000000

`endif

// [rtl/stee_pkg.sv]
// types of the system-management / thermal exception entry unit
// assumes nothing beyond the constants header
package stee_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SMI_DRAIN,
		ST_THM_DRAIN,
		ST_SMI_ENTER,
		ST_THM_ENTER
	} stee_state_t;

endpackage

// [rtl/stee_sync.sv]
// two-stage synchroniser, one per threshold-crossing channel
// assumes inputs may change at any time relative to clk_sys
`timescale 1ns/1ns

module stee_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_out
);

	logic [1:0] meta;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_ch
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					meta[g] <= 1'b0;
					sync_out[g] <= 1'b0;
				end else begin
					meta[g] <= async_in[g];
					sync_out[g] <= meta[g];
				end
			end
		end
	endgenerate

endmodule

// [rtl/stee_entry.sv]
// exception entry for the system-management and thermal-management interrupts
// assumes the core reports drain progress and its own exceptions synchronously
//
// Operation
// - system-management request enters on sys_mgmt_int_n pin
// - system-management beats ordinary external interrupt
// - stop dispatch, drain, let instruction exceptions first
// - system-management vector is base plus 0x01400
// - saved_pc gets address of next instruction
// - saved_status copies chosen bits, clears others
// - clear listed state bits, data_endian takes trap_endian
// - thermal request on either threshold crossing
// - crossing counts only with its thermal_int_on
// - ext_int_on masks the thermal interrupt
// - thermal drain: next completes, later blocked, stores drain
// - drain exceptions first; enter at recoverable halt
// - thermal vector is base plus 0x01700
`timescale 1ns/1ns
`include "stee_params.svh"

module stee_entry (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sys_mgmt_int_n,
	input wire logic ext_int_req,
	input wire logic thm_cross_a,
	input wire logic thm_cross_b,
	input wire logic thermal_int_on_a,
	input wire logic thermal_int_on_b,
	input wire logic [31:0] machine_state,
	input wire logic [31:0] next_pc,
	input wire logic pending_empty,
	input wire logic next_instr_done,
	input wire logic store_queue_empty,
	input wire logic core_exc_take,
	output logic dispatch_stop,
	output logic completion_block,
	output logic ext_int_hold,
	output logic smi_taken,
	output logic thm_taken,
	output logic state_load,
	output logic [31:0] entry_state,
	output logic [31:0] saved_pc,
	output logic [31:0] saved_status,
	output logic [31:0] vector_addr
);

	stee_pkg::stee_state_t st;
	stee_pkg::stee_state_t next_st;
	logic next_seen;
	logic [1:0] cross_sync;

	stee_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({thm_cross_b, thm_cross_a}),
		.sync_out(cross_sync)
	);

	// request decode
	wire ee_on = machine_state[`STEE_EE_BIT];
	wire smi_pin = !sys_mgmt_int_n;
	// ext_int_on also masks the pin so a held request cannot re-enter the handler
	wire smi_go = smi_pin && ee_on && !core_exc_take;
	wire thm_armed = (cross_sync[0] && thermal_int_on_a) ||
		(cross_sync[1] && thermal_int_on_b);
	wire thm_go = thm_armed && ee_on && !core_exc_take;
	wire next_done = next_seen || next_instr_done;
	wire halt_ok = next_done && store_queue_empty;
	wire smi_drained = pending_empty && !core_exc_take;
	wire thm_drained = halt_ok && !core_exc_take;
	wire in_enter = (st == stee_pkg::ST_SMI_ENTER) || (st == stee_pkg::ST_THM_ENTER);

	// entry values
	wire trap_endian = machine_state[`STEE_ILE_BIT];
	wire [31:0] endian_word = {{31{1'b0}}, trap_endian} << `STEE_LE_BIT;
	wire [31:0] next_entry_state = (machine_state & ~`STEE_MSR_CLR_MASK) | endian_word;
	wire [31:0] next_saved_status = machine_state & `STEE_SAVE_KEEP_MASK;
	wire [31:0] vec_base = machine_state[`STEE_IP_BIT] ? `STEE_VEC_BASE_HI : `STEE_VEC_BASE_LO;
	wire [31:0] smi_vec = vec_base + `STEE_SMI_VEC_OFS;
	wire [31:0] thm_vec = vec_base + `STEE_THM_VEC_OFS;
	wire [31:0] next_vector = (st == stee_pkg::ST_SMI_ENTER) ? smi_vec : thm_vec;

	// sequencing
	always_comb begin
		next_st = st;
		case (st)
			stee_pkg::ST_IDLE: begin
				if (smi_go) begin
					next_st = stee_pkg::ST_SMI_DRAIN;
				end else if (thm_go) begin
					next_st = stee_pkg::ST_THM_DRAIN;
				end
			end
			stee_pkg::ST_SMI_DRAIN: begin
				// an instruction exception is taken first; the held pin re-arms later
				if (core_exc_take) begin
					next_st = stee_pkg::ST_IDLE;
				end else if (smi_drained) begin
					next_st = stee_pkg::ST_SMI_ENTER;
				end
			end
			stee_pkg::ST_THM_DRAIN: begin
				if (core_exc_take) begin
					next_st = stee_pkg::ST_IDLE;
				end else if (thm_drained) begin
					next_st = stee_pkg::ST_THM_ENTER;
				end
			end
			stee_pkg::ST_SMI_ENTER: begin
				next_st = stee_pkg::ST_IDLE;
			end
			stee_pkg::ST_THM_ENTER: begin
				next_st = stee_pkg::ST_IDLE;
			end
			default: begin
				next_st = stee_pkg::ST_IDLE;
			end
		endcase
	end

	wire next_stop = (next_st != stee_pkg::ST_IDLE) && !(in_enter);
	wire next_block = (next_st == stee_pkg::ST_THM_DRAIN) ||
		(next_st == stee_pkg::ST_THM_ENTER);
	wire next_hold = (next_st == stee_pkg::ST_SMI_DRAIN) ||
		(next_st == stee_pkg::ST_SMI_ENTER);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= stee_pkg::ST_IDLE;
			next_seen <= 1'b0;
		end else begin
			st <= next_st;
			next_seen <= (st == stee_pkg::ST_THM_DRAIN) && next_done;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dispatch_stop <= 1'b0;
			completion_block <= 1'b0;
			ext_int_hold <= 1'b0;
		end else begin
			dispatch_stop <= next_stop;
			completion_block <= next_block;
			ext_int_hold <= next_hold;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			smi_taken <= 1'b0;
			thm_taken <= 1'b0;
			state_load <= 1'b0;
		end else begin
			smi_taken <= (st == stee_pkg::ST_SMI_ENTER);
			thm_taken <= (st == stee_pkg::ST_THM_ENTER);
			state_load <= in_enter;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			entry_state <= `STEE_WORD_RST;
			saved_pc <= `STEE_WORD_RST;
			saved_status <= `STEE_WORD_RST;
			vector_addr <= `STEE_WORD_RST;
		end else if (in_enter) begin
			entry_state <= next_entry_state;
			saved_pc <= next_pc;
			saved_status <= next_saved_status;
			vector_addr <= next_vector;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_smi_drain_end;
		(st == stee_pkg::ST_SMI_DRAIN) && smi_drained;
	endsequence

	sequence s_thm_drain_end;
		(st == stee_pkg::ST_THM_DRAIN) && thm_drained;
	endsequence

	sequence s_smi_start;
		(st == stee_pkg::ST_IDLE) && smi_go;
	endsequence

	property p_smi_entry;
		s_smi_drain_end ##1 1'b1 |=> smi_taken && state_load &&
			(vector_addr == $past(smi_vec));
	endproperty

	property p_thm_entry;
		s_thm_drain_end ##1 1'b1 |=> thm_taken && state_load &&
			(vector_addr == $past(thm_vec));
	endproperty

	AST_SMI_VECTOR: assert property (p_smi_entry)
		else $error("system-management entry missing or wrong vector");

	AST_THM_VECTOR: assert property (p_thm_entry)
		else $error("thermal entry missing or wrong vector");

	AST_SAVED_PC: assert property (state_load |-> saved_pc == $past(next_pc))
		else $error("saved_pc not the next instruction address");

	AST_SAVED_STATUS: assert property (state_load |->
		(saved_status[31] == $past(machine_state[31])) &&
		(saved_status[30:27] == 4'h0) && (saved_status[21:16] == 6'h00) &&
		(saved_status[15:0] == $past(machine_state[15:0])))
		else $error("saved_status bits wrong");

	AST_ENTRY_STATE: assert property (state_load |->
		!entry_state[`STEE_EE_BIT] && !entry_state[`STEE_PR_BIT] &&
		!entry_state[`STEE_IR_BIT] && !entry_state[`STEE_RI_BIT] &&
		(entry_state[`STEE_LE_BIT] == $past(machine_state[`STEE_ILE_BIT])) &&
		(entry_state[`STEE_IP_BIT] == $past(machine_state[`STEE_IP_BIT])))
		else $error("entry machine state wrong");

	AST_SMI_STOP_HOLD: assert property (s_smi_start |=>
		(dispatch_stop && ext_int_hold) [*1] ##1 (st != stee_pkg::ST_THM_DRAIN))
		else $error("system-management drain did not stop dispatch");

	AST_SMI_FIRST: assert property ((st == stee_pkg::ST_IDLE) && smi_go && thm_go
		|=> st == stee_pkg::ST_SMI_DRAIN)
		else $error("thermal taken ahead of system management");

	AST_THM_MASK: assert property ((st == stee_pkg::ST_IDLE) && (!ee_on || !thm_armed)
		&& !smi_go |=> st == stee_pkg::ST_IDLE)
		else $error("thermal drain started while masked or unarmed");

	AST_THM_ARMED: assert property ((st == stee_pkg::ST_IDLE) && $past(thm_cross_a, 2) &&
		$past(thm_cross_a, 3) && thermal_int_on_a && ee_on && !core_exc_take
		|=> st != stee_pkg::ST_IDLE)
		else $error("enabled threshold crossing ignored");

	AST_THM_HALT: assert property (thm_taken |-> $past(store_queue_empty, 2) &&
		$past(completion_block, 2))
		else $error("thermal entry before store queue drained");

	AST_EXC_FIRST: assert property ((st == stee_pkg::ST_THM_DRAIN || st ==
		stee_pkg::ST_SMI_DRAIN) && core_exc_take |=> (st == stee_pkg::ST_IDLE) ##1
		!smi_taken && !thm_taken)
		else $error("interrupt entered over an instruction exception");

endmodule

// [tb/stee_smi_src.sv]
// source model: system logic driving the request pin
// assumes req from the bench, smi_taken from the entry unit
`timescale 1ns/1ns
module stee_smi_src (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req,
	input wire logic smi_taken,
	output logic sys_mgmt_int_n
);
	logic seen = 1'b0;
	initial sys_mgmt_int_n = 1'b1;
	always @(negedge clk_sys) begin
		if (!rst_n || !req) begin
			sys_mgmt_int_n <= 1'b1;
			seen <= 1'b0;
		end else begin
			sys_mgmt_int_n <= seen;
			seen <= seen | smi_taken;
		end
	end
endmodule

// [tb/testbench.sv]
// self-checking bench of the exception entry unit
// assumes stee_entry and the source model stee_smi_src
`timescale 1ns/1ns
module testbench;
	logic clk_sys, rst_n, smi_req, sys_mgmt_int_n, ext_int_req, thm_cross_a, thm_cross_b;
	logic thermal_int_on_a, thermal_int_on_b, pending_empty, next_instr_done, store_queue_empty;
	logic core_exc_take, dispatch_stop, completion_block, ext_int_hold, smi_taken, thm_taken;
	logic state_load;
	logic [31:0] machine_state, next_pc, entry_state, saved_pc, saved_status, vector_addr;
	int n_errors = 0;
	int check_count = 0;
	stee_entry dut_u (.clk_sys, .rst_n, .sys_mgmt_int_n, .ext_int_req, .thm_cross_a, .thm_cross_b,
		.thermal_int_on_a, .thermal_int_on_b, .machine_state, .next_pc, .pending_empty,
		.next_instr_done, .store_queue_empty, .core_exc_take, .dispatch_stop, .completion_block,
		.ext_int_hold, .smi_taken, .thm_taken, .state_load, .entry_state, .saved_pc,
		.saved_status, .vector_addr);
	stee_smi_src src_u (.clk_sys, .rst_n, .req(smi_req), .smi_taken, .sys_mgmt_int_n);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic drain(input logic pe, nd, sq);
		{pending_empty, next_instr_done, store_queue_empty} = {pe, nd, sq};
	endtask
	task automatic wait_on(input logic load);
		int n = 0;
		while ((load ? state_load : dispatch_stop) !== 1'b1 && n < 12) begin
			tick(1);
			n++;
		end
	endtask
	task automatic stall();
		repeat (3) begin
			tick(1);
			check("state_load", state_load, 1'b0);
		end
	endtask
	// kind 0 thermal, 1 system-management, 2 both at once
	task automatic run(input int kind, input logic [31:0] ms, input logic exc);
		logic smi;
		logic [31:0] vec;
		smi = (kind != 0);
		vec = (ms[6] ? 32'hFFF00000 : 32'h00000000) + (smi ? 32'h00001400 : 32'h00001700);
		machine_state = ms;
		next_pc = ~ms;
		{smi_req, ext_int_req, thm_cross_b, thermal_int_on_b} = {smi, 1'b1, kind != 1, 1'b1};
		tick(2);
		if (!smi)
			check("dispatch_stop", dispatch_stop, 1'b0);
		wait_on(1'b0);
		check("dispatch_stop", dispatch_stop, 1'b1);
		check("ext_int_hold", ext_int_hold, smi);
		check("completion_block", completion_block, !smi);
		if (exc) begin
			drain(1'b1, 1'b1, 1'b1);
			core_exc_take = 1'b1;
			tick(1);
			core_exc_take = 1'b0;
			drain(1'b0, 1'b0, 1'b0);
			stall();
		end
		drain(1'b0, 1'b0, 1'b1);
		stall();
		drain(1'b0, 1'b1, 1'b0);
		tick(1);
		drain(1'b0, 1'b0, 1'b0);
		stall();
		drain(1'b1, 1'b0, 1'b1);
		wait_on(1'b1);
		check("smi_taken", smi_taken, smi);
		check("thm_taken", thm_taken, !smi);
		check("vector_addr", vector_addr, vec);
		check("saved_pc", saved_pc, ~ms);
		check("saved_status", saved_status, ms & 32'h87C0FFFF);
		check("entry_state", entry_state, (ms & ~32'h0004EF37) | {31'h0, ms[16]});
		// the core loads the entry state in the state_load cycle, so a held pin is masked
		machine_state = entry_state;
		tick(1);
		check("state_load", state_load, 1'b0);
		{smi_req, ext_int_req, thm_cross_b} = 3'h0;
		drain(1'b0, 1'b0, 1'b0);
		tick(5);
		$display("test %0d exc %0d done", kind, exc);
	endtask
	initial begin
		rst_n = 1'b0;
		{smi_req, ext_int_req, thm_cross_a, thm_cross_b} = 4'h0;
		{thermal_int_on_a, thermal_int_on_b, core_exc_take} = 3'h0;
		{machine_state, next_pc} = 64'h0;
		drain(1'b0, 1'b0, 1'b0);
		repeat (5) @(negedge clk_sys);
		rst_n = 1'b1;
		tick(2);
		run(1, 32'hA5C1F0F3, 1'b0);
		run(0, 32'h5A3E8F0C, 1'b0);
		run(1, 32'h5A3E8F0C, 1'b1);
		run(0, 32'hA5C1F0F3, 1'b1);
		run(2, 32'hA5C1F0F3, 1'b0);
		// channel a: masked twice, then taken
		{machine_state, thm_cross_a, thermal_int_on_a} = {32'h00000000, 2'h3};
		tick(6);
		check("dispatch_stop", dispatch_stop, 1'b0);
		{machine_state, thermal_int_on_a} = {32'h00008000, 1'b0};
		tick(6);
		check("dispatch_stop", dispatch_stop, 1'b0);
		thermal_int_on_a = 1'b1;
		wait_on(1'b0);
		check("dispatch_stop", dispatch_stop, 1'b1);
		drain(1'b1, 1'b1, 1'b1);
		wait_on(1'b1);
		check("thm_taken", thm_taken, 1'b1);
		$display("test channel a done");
		summarize();
	end
endmodule
